// >>> hdl/ftf_addr_counter.sv
// Purpose: One wrapping 12-bit address counter with a lap bit.
// Assumes: Clear and advance are synchronous to clk_sys.
// Notes:   The lap bit toggles on each wrap so full and empty differ.
`timescale 1ns/1ps
module ftf_addr_counter
    import ftf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    ftf_cnt_if.owner cnt
);

    ftf_cnt_state_t state;
    ftf_cnt_state_t next_state;

    // ------------------------------------------------------------------
    // Next value
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (cnt.clear) begin
            next_state = RST_PTR;
        end else if (cnt.advance) begin // [RL2]
            if (state.addr == cnt.topCount) begin
                next_state.addr = 12'h000; // [RL3]
                next_state.lap = ~state.lap;
            end else begin
                next_state.addr = state.addr + 12'h001; // [RL3]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= RST_PTR;
        end else begin
            state <= next_state;
        end
    end

    assign cnt.addr = state.addr;
    assign cnt.lap = state.lap;

endmodule // ftf_addr_counter

// >>> hdl/ftf_cnt_if.sv
// Purpose: Carries control and value of one address counter.
// Assumes: Single clock domain shared by both ends.
// Notes:   The top drives the controls; the counter drives the value.
`timescale 1ns/1ps
interface ftf_cnt_if;
    logic advance;
    logic clear;
    logic [11:0] topCount;
    logic [11:0] addr;
    logic lap;

    modport owner(input advance, input clear, input topCount,
                  output addr, output lap);
    modport user(output advance, output clear, output topCount,
                 input addr, input lap);
endinterface

// >>> hdl/ftf_pkg.sv
// Purpose: Shared constants and types for the FIFO flag and counter block.
// Assumes: APB slave with 32-bit data and an 8-bit byte address.
// Notes:   Every offset is named here, and most reset values and field positions.
package ftf_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int PTR_W = 12;
    localparam int THR_W = 12;
    localparam int DIFF_W = 13;
    localparam int ADDR_W = 8;
    localparam int INT_W = 6;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_AE_THR = 8'h04;
    localparam logic [7:0] ADDR_AF_THR = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_POINTERS = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_EMPTY_STOP = 0;
    localparam int CTRL_FULL_STOP = 1;
    localparam int CTRL_ASPECT_LO = 2;
    localparam int POINTERS_READ_LO = 16;
    localparam int INT_FULL = 0;
    localparam int INT_EMPTY = 1;
    localparam int INT_ALMOST_FULL = 2;
    localparam int INT_ALMOST_EMPTY = 3;
    localparam int INT_WRITE_BLOCKED = 4;
    localparam int INT_READ_BLOCKED = 5;

    // ------------------------------------------------------------------
    // Aspect ratios and their top counts
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ASPECT_4KX1 = 2'h0,
        ASPECT_2KX2 = 2'h1,
        ASPECT_1KX4 = 2'h2,
        ASPECT_512X9 = 2'h3
    } ftf_aspect_t;

    localparam logic [11:0] TOP_4KX1 = 12'hFFF;
    localparam logic [11:0] TOP_2KX2 = 12'h7FF;
    localparam logic [11:0] TOP_1KX4 = 12'h3FF;
    localparam logic [11:0] TOP_512X9 = 12'h1FF;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] RST_ASPECT = 2'h3;
    localparam logic [11:0] RST_AE_THR = 12'h000;
    localparam logic [11:0] RST_AF_THR = 12'hFFF;
    // Flags seen before the first edge: empty and almost empty
    localparam logic [3:0] RST_FLAGS_PREV = 4'hA;
    localparam logic [5:0] RST_INT_MASK = 6'h00;
    localparam logic [12:0] RST_PTR = 13'h0000;
    localparam logic [31:0] RST_RDATA = 32'h00000000;

    // ------------------------------------------------------------------
    // State of the top module
    // ------------------------------------------------------------------
    typedef struct packed {
        logic emptyStop;
        logic fullStop;
        logic [1:0] aspect;
        logic [11:0] aeThr;
        logic [11:0] afThr;
        logic [12:0] rdDly1;
        logic [12:0] rdDly2;
        logic [12:0] wrDly1;
        logic [12:0] wrDly2;
        logic [3:0] flagsPrev;
        logic [5:0] intStat;
        logic [5:0] intMask;
        logic [31:0] rdData;
        logic clearCnt;
    } ftf_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic lap;
    } ftf_cnt_state_t;

endpackage

// >>> hdl/ftf_top.sv
// Purpose: Address counters, full/empty and programmable flags of a FIFO.
// Assumes: One clock; write and read requests are synchronous to clk_sys.
// Notes:   Registers over APB with zero wait states; one level interrupt.
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] Almost-empty and almost-full thresholds are 12 bits, compared to difference.
// [RL2] Separate 12-bit write and read counters, each advancing once per operation.
// [RL3] Counters start at zero, reach depth minus one, then wrap to zero.
// [RL4] Almost-full is high while write minus read reaches the threshold.
// [RL5] Almost-empty is high while write minus read is at most threshold.
// [RL6] Thresholds count data bits, not words, so aspect ratio is honoured.
// [RL7] Almost-full stays high until the difference falls below the threshold.
// [RL8] Empty-stop freezes reads at empty; otherwise reads keep wrapping.
// [RL9] Full-stop freezes the write counter once the FIFO is full.
// [RL10] Full uses a twice-delayed read pointer, lingering two edges.
// [RL11] Empty uses a twice-delayed write pointer, lingering two edges.
// [RL12] Empty-stop and full-stop are active high and inhibit counting.
// [RL13] Writer grounds unused high data bits for narrow widths.
// [RL14] Difference is taken modulo the counter range, surviving wraps.
module ftf_top
    import ftf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic writeReq,
    input wire logic readReq,
    output logic [11:0] writePointer,
    output logic [11:0] readPointer,
    output logic fullFlag,
    output logic emptyFlag,
    output logic almostFullFlag,
    output logic almostEmptyFlag,
    output logic irq
);

    ftf_state_t state;
    ftf_state_t next_state;

    ftf_cnt_if wrCnt();
    ftf_cnt_if rdCnt();

    logic [11:0] topCount;
    logic [12:0] wordDiff;
    logic [12:0] bitDiff;
    logic full;
    logic empty;
    logic almostFull;
    logic almostEmpty;
    logic writeBlocked;
    logic readBlocked;
    logic [3:0] flagsNow;
    logic [5:0] events;
    logic setupPhase;
    logic accessPhase;
    logic mapped;
    logic [31:0] readMux;

    // ------------------------------------------------------------------
    // Address counters
    // ------------------------------------------------------------------
    ftf_addr_counter wrCounter (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .cnt(wrCnt)
    );

    ftf_addr_counter rdCounter (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .cnt(rdCnt)
    );

    always_comb begin
        case (state.aspect)
            ASPECT_4KX1: topCount = TOP_4KX1;
            ASPECT_2KX2: topCount = TOP_2KX2;
            ASPECT_1KX4: topCount = TOP_1KX4;
            default: topCount = TOP_512X9;
        endcase
    end

    // ------------------------------------------------------------------
    // Full and empty
    // ------------------------------------------------------------------
    // Compared against delayed copies, as a resynchronised pointer would
    // be; the flag is pessimistic for two edges but never optimistic.
    assign full = (wrCnt.addr == state.rdDly2[11:0])
                && (wrCnt.lap != state.rdDly2[12]); // [RL10]
    assign empty = (rdCnt.addr == state.wrDly2[11:0])
                 && (rdCnt.lap == state.wrDly2[12]); // [RL11]

    assign writeBlocked = writeReq && full && state.fullStop; // [RL9] [RL12]
    assign readBlocked = readReq && empty && state.emptyStop; // [RL8] [RL12]

    assign wrCnt.advance = writeReq && !writeBlocked; // [RL2] [RL9]
    // Without empty-stop a read past empty just rereads old words
    assign rdCnt.advance = readReq && !readBlocked; // [RL2] [RL8]
    assign wrCnt.clear = state.clearCnt;
    assign rdCnt.clear = state.clearCnt;
    assign wrCnt.topCount = topCount;
    assign rdCnt.topCount = topCount;

    // ------------------------------------------------------------------
    // Programmable flags
    // ------------------------------------------------------------------
    always_comb begin
        // Equal addresses on different laps mean a whole depth stored
        if ((wrCnt.addr == rdCnt.addr) && (wrCnt.lap != rdCnt.lap)) begin
            wordDiff = {1'b0, topCount} + 13'h0001;
        end else begin
            wordDiff = {1'b0, (wrCnt.addr - rdCnt.addr) & topCount}; // [RL14]
        end
        case (state.aspect)
            ASPECT_4KX1: bitDiff = wordDiff; // [RL6]
            ASPECT_2KX2: bitDiff = {wordDiff[11:0], 1'b0}; // [RL6]
            ASPECT_1KX4: bitDiff = {wordDiff[10:0], 2'b00}; // [RL6]
            default: bitDiff = {wordDiff[9:0], 3'b000} + wordDiff; // [RL6]
        endcase
    end

    // Level compare: holds while the difference stays at or above
    assign almostFull = bitDiff >= {1'b0, state.afThr}; // [RL1] [RL4] [RL7]
    assign almostEmpty = bitDiff <= {1'b0, state.aeThr}; // [RL1] [RL5]

    assign flagsNow = {almostEmpty, almostFull, empty, full};

    always_comb begin
        events = '0;
        events[INT_FULL] = full && !state.flagsPrev[0];
        events[INT_EMPTY] = empty && !state.flagsPrev[1];
        events[INT_ALMOST_FULL] = almostFull && !state.flagsPrev[2];
        events[INT_ALMOST_EMPTY] = almostEmpty && !state.flagsPrev[3];
        events[INT_WRITE_BLOCKED] = writeBlocked;
        events[INT_READ_BLOCKED] = readBlocked;
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;

    always_comb begin
        mapped = 1'b1;
        readMux = '0;
        if (paddr == ADDR_CTRL) begin
            readMux[CTRL_EMPTY_STOP] = state.emptyStop;
            readMux[CTRL_FULL_STOP] = state.fullStop;
            readMux[CTRL_ASPECT_LO +: 2] = state.aspect;
        end else if (paddr == ADDR_AE_THR) begin
            readMux[THR_W-1:0] = state.aeThr;
        end else if (paddr == ADDR_AF_THR) begin
            readMux[THR_W-1:0] = state.afThr;
        end else if (paddr == ADDR_STATUS) begin
            readMux[3:0] = flagsNow;
        end else if (paddr == ADDR_POINTERS) begin
            readMux[PTR_W-1:0] = wrCnt.addr;
            readMux[POINTERS_READ_LO +: PTR_W] = rdCnt.addr;
        end else if (paddr == ADDR_INT_STAT) begin
            readMux[INT_W-1:0] = state.intStat;
        end else if (paddr == ADDR_INT_MASK) begin
            readMux[INT_W-1:0] = state.intMask;
        end else begin
            mapped = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.clearCnt = 1'b0;
        next_state.rdDly1 = {rdCnt.lap, rdCnt.addr}; // [RL10]
        next_state.rdDly2 = state.rdDly1; // [RL10]
        next_state.wrDly1 = {wrCnt.lap, wrCnt.addr}; // [RL11]
        next_state.wrDly2 = state.wrDly1; // [RL11]
        // Counters still hold old values while the clear is pending
        if (state.clearCnt) begin
            next_state.rdDly1 = RST_PTR;
            next_state.wrDly1 = RST_PTR;
        end
        next_state.flagsPrev = flagsNow;
        next_state.intStat = state.intStat;
        if (setupPhase && !pwrite) begin
            next_state.rdData = readMux;
        end
        if (accessPhase && pwrite) begin
            if (paddr == ADDR_CTRL) begin
                next_state.emptyStop = pwdata[CTRL_EMPTY_STOP];
                next_state.fullStop = pwdata[CTRL_FULL_STOP];
                next_state.aspect = pwdata[CTRL_ASPECT_LO +: 2];
                // New depth invalidates both counters
                if (pwdata[CTRL_ASPECT_LO +: 2] != state.aspect) begin
                    next_state.clearCnt = 1'b1;
                    next_state.rdDly1 = RST_PTR;
                    next_state.rdDly2 = RST_PTR;
                    next_state.wrDly1 = RST_PTR;
                    next_state.wrDly2 = RST_PTR;
                end
            end else if (paddr == ADDR_AE_THR) begin
                next_state.aeThr = pwdata[THR_W-1:0]; // [RL1]
            end else if (paddr == ADDR_AF_THR) begin
                next_state.afThr = pwdata[THR_W-1:0]; // [RL1]
            end else if (paddr == ADDR_INT_STAT) begin
                next_state.intStat = state.intStat & ~pwdata[INT_W-1:0];
            end else if (paddr == ADDR_INT_MASK) begin
                next_state.intMask = pwdata[INT_W-1:0];
            end
        end
        // Set after the clear so a same-cycle event survives
        next_state.intStat = next_state.intStat | events;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state.emptyStop <= 1'b0;
            state.fullStop <= 1'b0;
            state.aspect <= RST_ASPECT;
            state.aeThr <= RST_AE_THR;
            state.afThr <= RST_AF_THR;
            state.rdDly1 <= RST_PTR;
            state.rdDly2 <= RST_PTR;
            state.wrDly1 <= RST_PTR;
            state.wrDly2 <= RST_PTR;
            state.flagsPrev <= RST_FLAGS_PREV;
            state.intStat <= '0;
            state.intMask <= RST_INT_MASK;
            state.rdData <= RST_RDATA;
            state.clearCnt <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = state.rdData;
    assign pready = 1'b1;
    assign pslverr = accessPhase && !mapped;
    assign writePointer = wrCnt.addr;
    assign readPointer = rdCnt.addr;
    assign fullFlag = full;
    assign emptyFlag = empty;
    assign almostFullFlag = almostFull;
    assign almostEmptyFlag = almostEmpty;
    assign irq = |(state.intStat & state.intMask);

endmodule // ftf_top

// >>> test/ftf_chk.sv
// Purpose: Port-level temporal checks of the FIFO flag and counter block.
// Assumes: One clock domain; counters may clear one cycle after an APB write.
// Notes:   Antecedents, bar those of a_af_full and a_ae_empty, skip cycles near APB writes for that reason.
`timescale 1ns/1ps
module ftf_chk (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic writeReq,
    input wire logic readReq,
    input wire logic [11:0] writePointer,
    input wire logic [11:0] readPointer,
    input wire logic fullFlag,
    input wire logic emptyFlag,
    input wire logic almostFullFlag,
    input wire logic almostEmptyFlag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic lastWr;
    logic calm;
    // Aspect writes clear counters a cycle late, so watch two cycles
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lastWr <= 1'b0;
        end else begin
            lastWr <= psel && penable && pwrite;
        end
    end
    assign calm = !(psel && penable && pwrite) && !lastWr;
    sequence s_wr_first;
        emptyFlag && !readReq && calm && $stable(writePointer) ##1
        emptyFlag && !readReq && calm && $changed(writePointer);
    endsequence
    sequence s_rd_first;
        fullFlag && !writeReq && calm && $stable(readPointer) ##1
        fullFlag && !writeReq && calm && $changed(readPointer);
    endsequence
    property p_wr_adv;
        writeReq && !fullFlag && calm |=> writePointer == 12'h000
            || writePointer == $past(writePointer) + 12'h001;
    endproperty
    a_wr_adv: assert property (p_wr_adv)
        else $error("write pointer did not step");
    property p_rd_adv;
        readReq && !emptyFlag && calm |=> readPointer == 12'h000
            || readPointer == $past(readPointer) + 12'h001;
    endproperty
    a_rd_adv: assert property (p_rd_adv)
        else $error("read pointer did not step");
    property p_empty_lag;
        s_wr_first |=> emptyFlag;
    endproperty
    a_empty_lag: assert property (p_empty_lag)
        else $error("empty cleared too early");
    property p_full_lag;
        s_rd_first |=> fullFlag;
    endproperty
    a_full_lag: assert property (p_full_lag)
        else $error("full cleared too early");
    property p_af_keep;
        almostFullFlag && !readReq && !fullFlag && calm |=> almostFullFlag;
    endproperty
    a_af_keep: assert property (p_af_keep)
        else $error("almost full dropped without a read");
    property p_ae_keep;
        almostEmptyFlag && !writeReq && !emptyFlag && calm |=> almostEmptyFlag;
    endproperty
    a_ae_keep: assert property (p_ae_keep)
        else $error("almost empty dropped without a write");
    property p_af_full;
        $stable(readPointer) [*3] ##0 fullFlag |-> almostFullFlag;
    endproperty
    a_af_full: assert property (p_af_full)
        else $error("full without almost full");
    property p_ae_empty;
        $stable(writePointer) [*3] ##0 emptyFlag |-> almostEmptyFlag;
    endproperty
    a_ae_empty: assert property (p_ae_empty)
        else $error("empty without almost empty");
endmodule // ftf_chk

bind ftf_top ftf_chk chk_u (.clk_sys, .nrst, .psel, .penable, .pwrite,
    .writeReq, .readReq, .writePointer, .readPointer, .fullFlag, .emptyFlag,
    .almostFullFlag, .almostEmptyFlag);

// >>> test/ftf_user_model.sv
// Purpose: Writer and reader user logic facing the FIFO counters.
// Assumes: Requests change just after a rising edge, one per side a cycle.
// Notes:   Slow mode requests every other cycle only.
`timescale 1ns/1ps
module ftf_user_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic start,
    input wire logic slow,
    input wire logic [15:0] nWr,
    input wire logic [15:0] nRd,
    output logic writeReq,
    output logic readReq,
    output logic busy
);
    logic [15:0] wLeft;
    logic [15:0] rLeft;
    logic phase;
    logic go;
    // No data lines here, so no high bits to ground
    assign go = !slow || phase;
    assign busy = start || wLeft != 16'h0 || rLeft != 16'h0 || writeReq
        || readReq;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wLeft <= 16'h0;
            rLeft <= 16'h0;
            phase <= 1'b0;
            writeReq <= 1'b0;
            readReq <= 1'b0;
        end else if (start) begin
            wLeft <= nWr;
            rLeft <= nRd;
        end else begin
            phase <= !phase;
            writeReq <= go && wLeft != 16'h0;
            readReq <= go && rLeft != 16'h0;
            if (go && wLeft != 16'h0) wLeft <= wLeft - 16'h1;
            if (go && rLeft != 16'h0) rLeft <= rLeft - 16'h1;
        end
    end
endmodule // ftf_user_model

// >>> test/tb.sv
// Purpose: Self-checking bench for the FIFO flag and counter block.
// Assumes: 512x9 aspect until the last scenario, which deepens it to 1Kx4.
// Notes:   Expectations come from running write and read totals.
`timescale 1ns/1ps
module tb
    import ftf_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic [15:0] nWr = 16'h0;
    logic [15:0] nRd = 16'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [11:0] writePointer, readPointer;
    logic pready, pslverr, writeReq, readReq, busy, irq, err;
    logic fullFlag, emptyFlag, almostFullFlag, almostEmptyFlag;
    logic [31:0] seed = 32'h4B;
    int fails = 0;
    int num_checks = 0;
    int tw = 0;
    int tr = 0;
    int ae = 0;
    int af = 4095;
    int dep = 512;
    int bw = 9;
    always #12.5 clk_sys = ~clk_sys;
    ftf_top dut_u (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .writeReq, .readReq, .writePointer,
        .readPointer, .fullFlag, .emptyFlag, .almostFullFlag, .almostEmptyFlag,
        .irq);
    ftf_user_model user_u (.clk_sys, .nrst, .start, .slow, .nWr, .nRd,
        .writeReq, .readReq, .busy);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkBit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            fails++;
            summarize();
        end
        #1;
    endtask
    task automatic burst(input int w, input int r, input logic s);
        int k;
        @(posedge clk_sys);
        nWr <= 16'(w);
        nRd <= 16'(r);
        slow <= s;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (busy !== 1'b0 && k < 3000);
        if (k >= 3000) begin
            fails++;
            summarize();
        end
        // Full and empty clear two edges after the far pointer moves
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic chkState();
        int d;
        d = tw - tr;
        chk("wptr", 32'(tw % dep), 32'(writePointer));
        chk("rptr", 32'(tr % dep), 32'(readPointer));
        chkBit("full", d == dep, fullFlag);
        chkBit("empty", d == 0, emptyFlag);
        chkBit("almost_full_flag", d * bw >= af, almostFullFlag);
        chkBit("almost_empty_flag", d * bw <= ae, almostEmptyFlag);
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        summarize();
    end
    initial begin
        int w;
        int r;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        chkBit("irq", 1'b0, irq);
        chkState();
        apb(1'b0, ADDR_AF_THR, 32'h0);
        chk("afthr", 32'hFFF, rd);
        apb(1'b0, ADDR_AE_THR, 32'h0);
        chk("aethr", 32'h0, rd);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", 32'hC, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        chkBit("slverr", 1'b1, err);
        // Thresholds in bits: three and 400 words of nine bits
        ae = 27;
        af = 3600;
        apb(1'b1, ADDR_AE_THR, 32'(ae));
        apb(1'b1, ADDR_AF_THR, 32'(af));
        burst(5, 0, 1'b1);
        tw += 5;
        chkState();
        repeat (4) begin
            w = int'(rnd() % 20) + 1;
            r = int'(rnd() % 32'(w));
            burst(w, r, 1'(rnd()));
            tw += w;
            tr += r;
            chkState();
        end
        w = 399 - (tw - tr);
        burst(w, 0, 1'b0);
        tw += w;
        chkState();
        burst(1, 0, 1'b0);
        tw += 1;
        chkState();
        burst(0, 1, 1'b0);
        tr += 1;
        chkState();
        apb(1'b1, ADDR_CTRL, 32'hE);
        burst(200, 0, 1'b0);
        tw = tr + 512;
        chkState();
        chkBit("irq", 1'b0, irq);
        apb(1'b1, ADDR_INT_MASK, 32'h10);
        chkBit("irq", 1'b1, irq);
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        chkBit("wblk", 1'b1, rd[INT_WRITE_BLOCKED]);
        apb(1'b0, ADDR_POINTERS, 32'h0);
        chk("ptrs", {4'h0, 12'(tr % 512), 4'h0, 12'(tw % 512)}, rd);
        apb(1'b1, ADDR_INT_STAT, 32'h3F);
        chkBit("irq", 1'b0, irq);
        apb(1'b1, ADDR_CTRL, 32'hD);
        apb(1'b1, ADDR_INT_MASK, 32'h20);
        burst(0, 600, 1'b0);
        tr = tw;
        chkState();
        chkBit("irq", 1'b1, irq);
        // Without the stop, reads run on past empty and wrap
        apb(1'b1, ADDR_CTRL, 32'hC);
        burst(0, 3, 1'b0);
        tr += 3;
        chk("rptr", 32'(tr % 512), 32'(readPointer));
        // A new depth restarts both counters a cycle after the write
        apb(1'b1, ADDR_CTRL, 32'h8);
        repeat (3) @(posedge clk_sys);
        #1;
        tw = 0;
        tr = 0;
        dep = 1024;
        bw = 4;
        chkState();
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'hA, rd);
        burst(7, 0, 1'b0);
        tw = 7;
        chkState();
        summarize();
    end
endmodule // tb
